// >>> src/ksd_consts.svh
// Purpose: constants of the keyboard/display scan controller
// Assumes: included by bare name from src/
// Notes:   definitions only
`ifndef KSD_CONSTS_SVH
`define KSD_CONSTS_SVH
// ==========================================================
// command opcodes, data bus bits 7..5
`define KSD_OP_MODE    3'h0
`define KSD_OP_CLOCK   3'h1
`define KSD_OP_RDFIFO  3'h2
`define KSD_OP_RDDISP  3'h3
`define KSD_OP_WRDISP  3'h4
`define KSD_OP_INHBLK  3'h5
`define KSD_OP_CLEAR   3'h6
`define KSD_OP_ENDINT  3'h7
// ==========================================================
// reset values
`define KSD_RST_DIV    5'h1f
`define KSD_RST_DISP   2'h1
`define KSD_RST_KEY    3'h0
`define KSD_DIV_MIN    5'h02
// ==========================================================
// fill codes
`define KSD_FILL_ZERO  8'h00
`define KSD_FILL_SPACE 8'h20
`define KSD_FILL_ONES  8'hff
// ==========================================================
// timing at the internal reference
`define KSD_REF_KHZ    100
`define KSD_SCAN_US    5100
`define KSD_DEB_US     10300
`define KSD_ROWS       8
`define KSD_ROW_TICKS  (`KSD_SCAN_US * `KSD_REF_KHZ / 1000 / `KSD_ROWS)
`define KSD_DEB_SCANS  (`KSD_DEB_US / `KSD_SCAN_US)
`define KSD_FIFO_FULL  4'h8
`define KSD_NO_KEY     8'hff
`endif

// >>> src/ksd_pkg.sv
// Purpose: types of the keyboard/display scan controller
// Assumes: nothing
// Notes:   constants live in ksd_consts.svh
package ksd_pkg;
  // ==========================================================
  // key debounce states, gray along idle-wait-hold
  typedef enum logic [1:0] {
    KB_IDLE = 2'h0,
    KB_WAIT = 2'h1,
    KB_HOLD = 2'h3
  } ksd_kb_state_t;
endpackage

// >>> src/ksd_ctrl.sv
// Purpose: keyboard/display scan controller behind an 8-bit host port
// Assumes: host strobes last several clocks; pins are asynchronous
// Notes:   return lines are active low (closed switch pulls low)
//
// Behaviour
// - command latched on write-strobe rise, select high
// - prescaler divides clock by 2..31, 0/1 as 2
// - divisor resets to 31, clear leaves it
// - row counters give 5.1ms scan, 10.3ms debounce
// - encoded binary scan or decoded one-of-four
// - decoded mode shows first four display words
// - debounce closed key, recheck, push with shift/control
// - chip select and select decode data/status/command
// - irq on fifo data or sensor change
// - read-fifo command sets sensor row and increment
// - read-display command sets address, increment, source
// - write-display command sets address, keeps read source
// - inhibit bits mask nibble writes, blank bits blank
// - blanked nibble shows latest clear code
// - blank output low when both nibbles blanked or digit switch
// - bits 7..4 to port a, 3..0 to b
// - clear code 10x zeros, 110 20h, 111 ones
// - refuse display writes, status msb while clearing
// - fifo clear resets status, irq, sensor row
// - clear-all clears display, fifo, resyncs timing
// - end-interrupt lowers sensor-mode irq (keyboard irq ignores it), re-enables sensor writes
// - error bit gates sensor/error flag, special error
// - status holds overrun, underrun, full, count
// - reset to 16-char left, encoded, 2-key lockout
// - each keyboard fifo read drops irq, rises if data
// - fifo entry control, shift, row, column
`timescale 1ns/1ps
`include "ksd_consts.svh"
module ksd_ctrl #(
  parameter int ROW_TICKS = `KSD_ROW_TICKS, // reference ticks per row
  parameter int DEB_SCANS = `KSD_DEB_SCANS  // scans before recheck
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       cmd_data_select_i,
  input  wire logic [7:0] db_i,
  output logic      [7:0] db_o,
  output logic            db_oe_n_o,
  input  wire logic [7:0] return_lines_i,
  input  wire logic       shift_i,
  input  wire logic       control_strobe_input_i,
  output logic      [3:0] scan_lines_o,
  output logic      [3:0] display_port_a_o,
  output logic      [3:0] display_port_b_o,
  output logic            display_blank_n_o,
  output logic            irq_o
);
  // ==========================================================
  // input synchronisers
  logic [21:0] meta_reg;      // first stage, read by sync only
  logic [21:0] sync_reg;      // second stage
  logic        wr_q_reg;      // previous write strobe
  logic        rd_q_reg;      // previous read strobe
  logic        stb_q_reg;     // previous control/strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= 22'h3fffff;
      sync_reg <= 22'h3fffff;
    end else begin
      meta_reg <= {cs_n_i, rd_n_i, wr_n_i, cmd_data_select_i, db_i,
                   return_lines_i, shift_i, control_strobe_input_i};
      sync_reg <= meta_reg;
    end
  end
  wire       s_cs_n = sync_reg[21];
  wire       s_rd_n = sync_reg[20];
  wire       s_wr_n = sync_reg[19];
  wire       s_a0   = sync_reg[18];
  wire [7:0] s_db   = sync_reg[17:10];
  wire [7:0] ret    = sync_reg[9:2];
  wire       s_shf  = sync_reg[1];
  wire       s_stb  = sync_reg[0];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q_reg  <= 1'b1;
      rd_q_reg  <= 1'b1;
      stb_q_reg <= 1'b1;
    end else begin
      wr_q_reg  <= s_wr_n;
      rd_q_reg  <= s_rd_n;
      stb_q_reg <= s_stb;
    end
  end
  // ==========================================================
  // host bus decode
  wire wr_rise = s_wr_n & ~wr_q_reg & ~s_cs_n;
  wire rd_rise = s_rd_n & ~rd_q_reg & ~s_cs_n;
  wire cmd_wr  = wr_rise & s_a0;
  wire dat_wr  = wr_rise & ~s_a0;
  wire dat_rd  = rd_rise & ~s_a0;
  wire [2:0] op = s_db[7:5];
  wire cmd_mode = cmd_wr & (op == `KSD_OP_MODE);
  wire cmd_clk  = cmd_wr & (op == `KSD_OP_CLOCK);
  wire cmd_rff  = cmd_wr & (op == `KSD_OP_RDFIFO);
  wire cmd_rdd  = cmd_wr & (op == `KSD_OP_RDDISP);
  wire cmd_wrd  = cmd_wr & (op == `KSD_OP_WRDISP);
  wire cmd_inh  = cmd_wr & (op == `KSD_OP_INHBLK);
  wire cmd_clr  = cmd_wr & (op == `KSD_OP_CLEAR);
  wire cmd_eoi  = cmd_wr & (op == `KSD_OP_ENDINT);
  // clear command fields
  wire clr_disp = cmd_clr & (s_db[4] | s_db[0]);
  wire clr_fifo = cmd_clr & (s_db[1] | s_db[0]);
  wire resync   = cmd_clr & s_db[0];
  wire [7:0] fill = (s_db[4:2] == 3'h7) ? `KSD_FILL_ONES :
                    (s_db[4:2] == 3'h6) ? `KSD_FILL_SPACE :
                                          `KSD_FILL_ZERO;
  // ==========================================================
  // command registers
  logic [1:0] disp_mode_reg;  // x0: 8 chars, x1: 16 chars
  logic [2:0] key_mode_reg;   // bit0 decoded, 2:1 kind
  logic [4:0] prescale_divisor_reg;
  logic       rd_disp_reg;    // data reads from display ram
  logic       auto_increment_flag_reg; // display side
  logic [3:0] disp_addr_reg;
  logic       sens_ai_reg;    // sensor side increment
  logic [2:0] row_address_reg; // sensor read row
  logic [3:0] inh_blk_reg;    // iwa, iwb, blank_a, blank_b
  logic [7:0] blank_code_reg;
  logic       err_en_reg;
  wire decoded = key_mode_reg[0];
  wire nkro    = key_mode_reg[2:1] == 2'h1;
  wire sensor  = key_mode_reg[2:1] == 2'h2;
  wire strobed = key_mode_reg[2:1] == 2'h3;
  wire inhibit_write_a = inh_blk_reg[3];
  wire inhibit_write_b = inh_blk_reg[2];
  wire blank_a = inh_blk_reg[1];
  wire blank_b = inh_blk_reg[0];
  logic clr_busy_reg;         // display unavailable
  wire fifo_rd = dat_rd & ~rd_disp_reg;
  wire disp_wr = dat_wr & ~clr_busy_reg;
  wire disp_step = auto_increment_flag_reg &
                   (disp_wr | (dat_rd & rd_disp_reg));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      disp_mode_reg <= `KSD_RST_DISP;
      key_mode_reg  <= `KSD_RST_KEY;
      prescale_divisor_reg <= `KSD_RST_DIV;
      rd_disp_reg   <= 1'b0;
      auto_increment_flag_reg <= 1'b0;
      disp_addr_reg <= 4'h0;
      sens_ai_reg   <= 1'b0;
      row_address_reg <= 3'h0;
      inh_blk_reg   <= 4'h0;
      blank_code_reg <= `KSD_FILL_ZERO;
      err_en_reg    <= 1'b0;
    end else begin
      if (cmd_mode) begin
        disp_mode_reg <= s_db[4:3];
        key_mode_reg  <= s_db[2:0];
      end
      if (cmd_clk)
        prescale_divisor_reg <= s_db[4:0];
      if (cmd_rff) begin
        rd_disp_reg <= 1'b0;
        sens_ai_reg <= s_db[4];
      end
      if (cmd_rdd)
        rd_disp_reg <= 1'b1;
      if (cmd_rdd | cmd_wrd) begin
        auto_increment_flag_reg <= s_db[4];
        disp_addr_reg <= s_db[3:0];
      end else if (disp_step) begin
        disp_addr_reg <= disp_addr_reg + 4'h1;
      end
      // sensor row pointer
      if (cmd_rff & sensor)
        row_address_reg <= s_db[2:0];
      else if (clr_fifo)
        row_address_reg <= 3'h0;
      else if (fifo_rd & sensor & sens_ai_reg)
        row_address_reg <= row_address_reg + 3'h1;
      if (cmd_inh)
        inh_blk_reg <= s_db[3:0];
      if (cmd_clr)
        blank_code_reg <= fill;
      if (cmd_eoi)
        err_en_reg <= s_db[4];
    end
  end
  // ==========================================================
  // prescaler and scan timing chain
  logic [4:0] pre_cnt_reg;
  logic [5:0] row_cnt_reg;    // reference ticks within a row
  logic [3:0] scan_reg;
  wire [4:0] div_eff = (prescale_divisor_reg < `KSD_DIV_MIN) ?
                       `KSD_DIV_MIN : prescale_divisor_reg;
  wire tick = pre_cnt_reg == div_eff - 5'h1;
  wire row_step = tick & (row_cnt_reg == 6'(ROW_TICKS - 1));
  wire [3:0] scan_mask = decoded ? 4'h3 :
                         (disp_mode_reg[0] ? 4'hf : 4'h7);
  wire [2:0] kb_row = decoded ? {1'b0, scan_reg[1:0]} : scan_reg[2:0];
  // clear-all restarts the chain so scans begin aligned
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_cnt_reg <= 5'h0;
      row_cnt_reg <= 6'h0;
      scan_reg    <= 4'h0;
    end else if (resync) begin
      pre_cnt_reg <= 5'h0;
      row_cnt_reg <= 6'h0;
      scan_reg    <= 4'h0;
    end else begin
      pre_cnt_reg <= tick ? 5'h0 : pre_cnt_reg + 5'h1;
      if (row_step) begin
        row_cnt_reg <= 6'h0;
        scan_reg    <= (scan_reg + 4'h1) & scan_mask;
      end else if (tick) begin
        row_cnt_reg <= row_cnt_reg + 6'h1;
      end
    end
  end
  // ==========================================================
  // display ram and clear engine
  logic [7:0] disp_ram [16];
  logic [3:0] clr_idx_reg;
  wire  [7:0] wr_word = {inhibit_write_a ? disp_ram[disp_addr_reg][7:4]
                                         : s_db[7:4],
                         inhibit_write_b ? disp_ram[disp_addr_reg][3:0]
                                         : s_db[3:0]};
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_busy_reg <= 1'b0;
      clr_idx_reg  <= 4'h0;
    end else if (clr_disp) begin
      clr_busy_reg <= 1'b1;
      clr_idx_reg  <= 4'h0;
    end else if (clr_busy_reg) begin
      clr_idx_reg  <= clr_idx_reg + 4'h1;
      clr_busy_reg <= clr_idx_reg != 4'hf;
    end
  end
  // one word per clock while clearing; host writes refused meanwhile
  always_ff @(posedge clk_i) begin
    if (clr_busy_reg)
      disp_ram[clr_idx_reg] <= blank_code_reg;
    else if (disp_wr)
      disp_ram[disp_addr_reg] <= wr_word;
  end
  // ==========================================================
  // key debounce
  ksd_pkg::ksd_kb_state_t kb_state_reg;
  logic [2:0] key_row_reg;
  logic [2:0] key_col_reg;
  logic [1:0] deb_cnt_reg;    // scans seen at the key's row
  function automatic logic [2:0] first_low(input logic [7:0] v);
    first_low = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!v[i])
        first_low = 3'(i);
    end
  endfunction
  wire key_down = ret != `KSD_NO_KEY;
  wire kb_mode  = ~sensor & ~strobed;
  wire at_key   = row_step & (kb_row == key_row_reg);
  wire other    = row_step & key_down & (kb_row != key_row_reg);
  wire deb_done = at_key & (deb_cnt_reg == 2'(DEB_SCANS - 1));
  wire kb_push  = kb_mode & (kb_state_reg == ksd_pkg::KB_WAIT) &
                  deb_done & ~ret[key_col_reg];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kb_state_reg <= ksd_pkg::KB_IDLE;
      key_row_reg  <= 3'h0;
      key_col_reg  <= 3'h0;
      deb_cnt_reg  <= 2'h0;
    end else if (!kb_mode | resync) begin
      kb_state_reg <= ksd_pkg::KB_IDLE;
    end else begin
      unique case (kb_state_reg)
        ksd_pkg::KB_IDLE: begin              // look for a closure
          if (row_step & key_down) begin
            key_row_reg  <= kb_row;
            key_col_reg  <= first_low(ret);
            deb_cnt_reg  <= 2'h0;
            kb_state_reg <= ksd_pkg::KB_WAIT;
          end
        end
        ksd_pkg::KB_WAIT: begin
          if (other & ~nkro) begin           // lockout: restart
            key_row_reg <= kb_row;
            key_col_reg <= first_low(ret);
            deb_cnt_reg <= 2'h0;
          end else if (deb_done) begin
            kb_state_reg <= ret[key_col_reg] ? ksd_pkg::KB_IDLE
                                             : ksd_pkg::KB_HOLD;
          end else if (at_key) begin
            deb_cnt_reg <= deb_cnt_reg + 2'h1;
          end
        end
        ksd_pkg::KB_HOLD: begin              // wait for release
          if (at_key & ret[key_col_reg])
            kb_state_reg <= ksd_pkg::KB_IDLE;
        end
        default: kb_state_reg <= ksd_pkg::KB_IDLE;
      endcase
    end
  end
  // ==========================================================
  // fifo / sensor ram
  logic [7:0] fifo_ram [8];
  logic [2:0] wr_ptr_reg;
  logic [2:0] rd_ptr_reg;
  logic [3:0] count_reg;
  logic       over_reg;
  logic       under_reg;
  logic       se_reg;
  wire full     = count_reg == `KSD_FIFO_FULL;
  wire stb_push = strobed & s_stb & ~stb_q_reg;
  wire push     = kb_push | stb_push;
  wire push_ok  = push & ~full & ~(nkro & se_reg);
  wire [7:0] push_data = strobed ? ret :
    {s_stb, s_shf, key_row_reg, key_col_reg};
  wire pop      = fifo_rd & ~sensor & (count_reg != 4'h0);
  wire sens_wr  = sensor & row_step & ~irq_o;
  wire sens_chg = sens_wr & (fifo_ram[kb_row] != ret);
  wire se_set   = err_en_reg & ((sens_wr & key_down) |
                  (nkro & other &
                   (kb_state_reg == ksd_pkg::KB_WAIT)));
  always_ff @(posedge clk_i) begin
    if (push_ok)
      fifo_ram[wr_ptr_reg] <= push_data;
    else if (sens_wr)
      fifo_ram[kb_row] <= ret;
  end
  // a new event in the clearing cycle still sets its flag
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      count_reg  <= 4'h0;
      over_reg   <= 1'b0;
      under_reg  <= 1'b0;
      se_reg     <= 1'b0;
    end else begin
      if (clr_fifo) begin
        wr_ptr_reg <= 3'h0;
        rd_ptr_reg <= 3'h0;
        count_reg  <= 4'h0;
      end else begin
        wr_ptr_reg <= wr_ptr_reg + 3'(push_ok);
        rd_ptr_reg <= rd_ptr_reg + 3'(pop);
        count_reg  <= count_reg + 4'(push_ok) - 4'(pop);
      end
      over_reg  <= (push & full) | (over_reg & ~clr_fifo);
      under_reg <= (fifo_rd & ~sensor & (count_reg == 4'h0)) |
                   (under_reg & ~clr_fifo);
      se_reg    <= se_set | (se_reg & ~clr_fifo);
    end
  end
  // ==========================================================
  // status, read data and pins
  wire [7:0] status = {clr_busy_reg, se_reg & err_en_reg, over_reg,
                       under_reg, full, count_reg[2:0]};
  wire [7:0] rd_val = s_a0 ? status :
                      rd_disp_reg ? disp_ram[disp_addr_reg] :
                      sensor ? fifo_ram[row_address_reg] :
                               fifo_ram[rd_ptr_reg];
  // decoded scan may start from a high count; only words 0..3 show
  wire [3:0] disp_idx = decoded ? {2'h0, scan_reg[1:0]} : scan_reg;
  wire [7:0] shown = disp_ram[disp_idx];
  wire [3:0] scan_out = decoded ? 4'h1 << scan_reg[1:0]
                                : scan_reg;
  wire       digit_sw = scan_out != scan_lines_o; // mode change moves digit
  // keyboard irq follows the count; a read forces one low cycle
  wire [3:0] cnt_next = clr_fifo ? 4'h0 :
                        count_reg + 4'(push_ok) - 4'(pop);
  wire irq_kb   = (cnt_next != 4'h0) & ~fifo_rd;
  wire irq_sens = sens_chg | (irq_o & ~clr_fifo & ~cmd_eoi &
                  ~(fifo_rd & ~sens_ai_reg));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      db_o              <= 8'h00;
      db_oe_n_o         <= 1'b1;
      scan_lines_o      <= 4'h0;
      display_port_a_o  <= 4'h0;
      display_port_b_o  <= 4'h0;
      display_blank_n_o <= 1'b0;
      irq_o             <= 1'b0;
    end else begin
      db_o      <= rd_val;
      db_oe_n_o <= s_cs_n | s_rd_n;
      scan_lines_o <= scan_out;
      display_port_a_o <= blank_a ? blank_code_reg[7:4]
                                  : shown[7:4];
      display_port_b_o <= blank_b ? blank_code_reg[3:0]
                                  : shown[3:0];
      display_blank_n_o <= ~((blank_a & blank_b) | digit_sw |
                             (row_cnt_reg == 6'h0));
      irq_o <= sensor ? irq_sens : irq_kb;
    end
  end
endmodule

// >>> tb/ksd_ctrl_properties.sv
// Purpose: port-level properties of the scan controller
// Assumes: bound to ksd_ctrl; host strobes pass 2 sync flops
// Notes:   windows allow the 3-clock sync and register delay
`timescale 1ns/1ps
module ksd_ctrl_properties (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       cs_n_i,
  input wire logic       rd_n_i,
  input wire logic       wr_n_i,
  input wire logic       cmd_data_select_i,
  input wire logic [7:0] db_i,
  input wire logic       db_oe_n_o,
  input wire logic [3:0] scan_lines_o,
  input wire logic       display_blank_n_o,
  input wire logic       irq_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // command write seen at the pins, opcode in bits 7..5
  sequence s_cmd(op);
    $rose(wr_n_i) && !cs_n_i && cmd_data_select_i && db_i[7:5] == op;
  endsequence
  // ==========================================================
  // bus, blanking and irq relations
  property p_oe_cs;
    cs_n_i [*4] |-> db_oe_n_o;
  endproperty
  property p_oe_rd;
    rd_n_i [*4] |-> db_oe_n_o;
  endproperty
  property p_oe_on;
    (!cs_n_i && !rd_n_i) [*4] |-> !db_oe_n_o;
  endproperty
  property p_irq_rst;
    $rose(reset_n_i) |-> !irq_o && db_oe_n_o;
  endproperty
  property p_cf;
    s_cmd(3'h6) ##0 db_i[1] |-> ##[3:6] !irq_o;
  endproperty
  property p_rd_irq;
    $rose(rd_n_i) && !cs_n_i && !cmd_data_select_i |-> ##[1:5] !irq_o;
  endproperty
  property p_blank;
    s_cmd(3'h5) ##0 db_i[1:0] == 2'h3 |-> ##6 (!display_blank_n_o) [*4];
  endproperty
  property p_blank_row;
    $changed(scan_lines_o) |-> ##[0:2] !display_blank_n_o;
  endproperty
  property p_dec;
    s_cmd(3'h0) ##0 db_i[0] |-> ##8 $onehot(scan_lines_o) [*8];
  endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("bus driven while deselected");
  a_oe_rd: assert property (p_oe_rd)
    else $error("bus driven without read");
  a_oe_on: assert property (p_oe_on)
    else $error("read not answered on bus");
  a_irq_rst: assert property (p_irq_rst)
    else $error("outputs wrong after reset");
  a_cf: assert property (p_cf)
    else $error("fifo clear kept irq");
  a_rd_irq: assert property (p_rd_irq)
    else $error("data read kept irq");
  a_blank: assert property (p_blank)
    else $error("blank output not low");
  a_blank_row: assert property (p_blank_row)
    else $error("digit switch not blanked");
  a_dec: assert property (p_dec)
    else $error("decoded scan not one-hot");
endmodule

// >>> tb/ksd_host.sv
// Purpose: host processor model on the 8-bit port
// Assumes: strobes held 4 clocks, bus released between cycles
// Notes:   read data handed back with a one-cycle note pulse
`timescale 1ns/1ps
module ksd_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] db_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            a0_o,
  output logic      [7:0] db_o,
  output logic            done_o,
  output logic      [7:0] data_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    a0_o = 1'b0;
    db_o = 8'h5a;
    done_o = 1'b0;
    data_o = 8'h00;
  end
  // ==========================================================
  // write cycle: command when a0 high, ram data when low
  task automatic wr(input logic a0, input logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    a0_o <= a0;
    db_o <= d;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1; // taken on this rise
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    db_o <= ~d; // released bus must not keep the old byte
  endtask
  // ==========================================================
  // read cycle, data taken as rd rises
  task automatic rd(input logic a0, input logic note);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    a0_o <= a0;
    rd_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    data_o <= db_i;
    done_o <= note;
    rd_n_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    cs_n_o <= 1'b1;
  endtask
endmodule

// >>> tb/ksd_ctrl_tb.sv
// Purpose: self-checking bench of the scan controller
// Assumes: host model drives the port, matrix model the lines
// Notes:   short row count and divisor keep the run brief
`timescale 1ns/1ps
module ksd_ctrl_tb;
  logic       clk_i, reset_n_i, cs_n, rd_n, wr_n, a0, oe_n, done;
  logic       shift, cntl, blank_n, irq, key_on;
  logic [7:0] hdb, ddb, bus, rl, hdata, d, fill;
  logic [3:0] scan, pa, pb, scan_q;
  logic [2:0] krow, kcol;
  logic [7:0] ram[16];
  logic [7:0] expq[$];       // notes of expected read data
  logic [31:0] per;          // last measured row length
  int         run, cyc, mismatches, n_checks, seed;
  logic [7:0] divc[3] = '{8'h20, 8'h21, 8'h25};
  int         divr[3] = '{2, 2, 5};  // divisor in force, 0/1 read as 2
  logic [7:0] clrc[4] = '{8'hc1, 8'hdc, 8'hd0, 8'hd8};
  logic [7:0] clrf[4] = '{8'h00, 8'hff, 8'h00, 8'h20};
  // ==========================================================
  // bus resolution and key matrix, one closed key
  assign bus = !oe_n ? ddb : hdb;
  assign rl = (key_on && scan[2:0] == krow) ? ~(8'h01 << kcol) : 8'hff;
  ksd_ctrl #(.ROW_TICKS(2), .DEB_SCANS(2)) dut (
    .clk_i, .reset_n_i, .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cmd_data_select_i(a0), .db_i(bus), .db_o(ddb), .db_oe_n_o(oe_n),
    .return_lines_i(rl), .shift_i(shift), .control_strobe_input_i(cntl),
    .scan_lines_o(scan), .display_port_a_o(pa), .display_port_b_o(pb),
    .display_blank_n_o(blank_n), .irq_o(irq));
  ksd_host host (.clk_i, .db_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .a0_o(a0), .db_o(hdb), .done_o(done), .data_o(hdata));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // note the expectation, then run the read
  task automatic rx(input logic sel, input logic [7:0] e);
    expq.push_back(e);
    host.rd(sel, 1'b1);
  endtask
  // row length and hang limit, counted every clock
  always @(posedge clk_i) begin
    scan_q <= scan;
    run <= (scan != scan_q) ? 1 : run + 1;
    if (scan != scan_q) per <= run;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // read result against oldest note
  always @(posedge clk_i)
    if (done === 1'b1) chk("rd_data", hdata, expq.pop_front());
  // ports mid-row: the word under the scan, or the blank code
  task automatic ports(input logic dec, input logic blk);
    int i;
    repeat (8) begin
      do @(posedge clk_i); while (run != 4);
      i = dec ? (scan[3] ? 3 : scan[2] ? 2 : scan[1]) : scan;
      chk("ports", {pa, pb}, blk ? fill : ram[i]);
      if (dec) chk("onehot", $onehot(scan), 1);
      if (blk) chk("blank_n", blank_n, 0);
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    {key_on, shift, cntl, krow, kcol} = '0;
    seed = 50758;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("row_len", per, 62);
    for (int k = 0; k < 3; k++) begin
      host.wr(1'b1, divc[k]);
      repeat (150) @(posedge clk_i);
      chk("row_len", per, divr[k] * 2);
    end
    for (int k = 0; k < 4; k++) begin
      host.wr(1'b1, clrc[k]);
      rx(1'b1, 8'h80); // busy while clearing
      host.wr(1'b1, 8'h70);
      for (int j = 0; j < 16; j++) rx(1'b0, clrf[k]);
      fill = clrf[k];
    end
    chk("row_len", per, divr[2] * 2);
    host.wr(1'b1, 8'h40);
    host.wr(1'b1, 8'h90);
    for (int j = 0; j < 16; j++) begin
      d = 8'($random(seed));
      ram[j] = d;
      host.wr(1'b0, d);
    end
    host.wr(1'b1, 8'ha8);
    host.wr(1'b1, 8'h80);
    d = 8'($random(seed));
    ram[0] = {ram[0][7:4], d[3:0]}; // a nibble kept
    host.wr(1'b0, d);
    host.wr(1'b1, 8'ha0);
    host.rd(1'b0, 1'b0); // source is still the empty fifo
    rx(1'b1, 8'h10); // underrun
    host.wr(1'b1, 8'h70);
    for (int j = 0; j < 16; j++) rx(1'b0, ram[j]);
    ports(1'b0, 1'b0);
    host.wr(1'b1, 8'h09); // 16 digits, decoded scan
    ports(1'b1, 1'b0);
    host.wr(1'b1, 8'ha3);
    ports(1'b1, 1'b1);
    host.wr(1'b1, 8'ha0);
    host.wr(1'b1, 8'h08);
    @(posedge clk_i);
    {cntl, shift, kcol, krow} <= 8'($random(seed));
    key_on <= 1'b1;
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk_i);
    chk("irq", irq, 1);
    rx(1'b1, 8'h11);
    host.wr(1'b1, 8'h40);
    rx(1'b0, {cntl, shift, krow, kcol});
    key_on <= 1'b0;
    repeat (600) @(posedge clk_i);
    key_on <= 1'b1;
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk_i);
    host.wr(1'b1, 8'hc2);
    rx(1'b1, 8'h00);
    chk("irq", irq, 0);
    repeat (20) @(posedge clk_i);
    // strobed entry: a strobe rise pushes the idle return lines
    key_on <= 1'b0;
    cntl   <= 1'b0;
    host.wr(1'b1, 8'h0e); // strobed mode
    cntl <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("irq", irq, 1);
    rx(1'b0, 8'hff);
    repeat (20) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
bind ksd_ctrl ksd_ctrl_properties u_props (.clk_i, .reset_n_i, .cs_n_i,
  .rd_n_i, .wr_n_i, .cmd_data_select_i, .db_i, .db_oe_n_o,
  .scan_lines_o, .display_blank_n_o, .irq_o);
